/* rtl/gbch_handler.sv */
// module: general bus command handler with avalon-mm control registers
`timescale 1ns/1ps
`default_nettype none
module gbch_handler
  import gbch_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic NRST,
  input wire logic REN,
  input wire logic IFC,
  input wire logic CMD_LLO,
  input wire logic CMD_GTL,
  input wire logic CMD_DCL,
  input wire logic CMD_SDC,
  input wire logic CMD_GET,
  input wire logic CMD_MLA,
  input wire logic CMD_MTA,
  input wire logic CMD_UNL,
  input wire logic CMD_UNT,
  input wire logic CMD_SPOLL,
  input wire logic [7:0] SPOLL_STATUS,
  input wire logic KEY_LOCAL,
  input wire logic [7:0] KEYS_IN,
  input wire logic [3:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  output logic TALK_LED,
  output logic LISTEN_LED,
  output logic REMOTE_LED,
  output logic LOCKOUT,
  output logic [7:0] KEYS_OUT,
  output logic CLEAR_PULSE,
  output logic SLAVE_CLEAR,
  output logic TRIG_START,
  output logic [7:0] SPOLL_BYTE,
  output logic SPOLL_VALID,
  output logic SLAVE_MODE,
  output logic [8:0] RELAY_STEP,
  output logic [8:0] MEM_STEP,
  output logic RELAYS_OPEN,
  output logic EDIT_PTR_RELAYS,
  output logic [4:0] BUS_ADDR
);
  // =====================================================================
  // pin synchronisers
  localparam int NSYNC = 14;
  logic [NSYNC-1:0] s1_r, s2_r;
  logic [NSYNC-1:0] pins;
  logic [7:0] keys_s1_r, keys_s2_r;
  assign pins = {REN, IFC, CMD_LLO, CMD_GTL, CMD_DCL, CMD_SDC, CMD_GET, CMD_MLA,
                 CMD_MTA, CMD_UNL, CMD_UNT, CMD_SPOLL, KEY_LOCAL, 1'b0};
  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      s1_r <= '0;
      s2_r <= '0;
      keys_s1_r <= '0;
      keys_s2_r <= '0;
    end else begin
      s1_r <= pins;
      s2_r <= s1_r;
      keys_s1_r <= KEYS_IN;
      keys_s2_r <= keys_s1_r;
    end
  end
  // only remote enable and interface clear act as levels; the rest act on edges
  logic ren, ifc;
  assign ren = s2_r[NSYNC-1];
  assign ifc = s2_r[NSYNC-2];
  // command strobes are levels on the pins; act on rising edges only
  logic [NSYNC-1:0] s3_r;
  always_ff @(posedge REF_CLK) begin
    if (!NRST) s3_r <= '0;
    else s3_r <= s2_r;
  end
  logic [NSYNC-1:0] rise;
  assign rise = s2_r & ~s3_r;
  logic e_llo, e_gtl, e_dcl, e_sdc, e_get, e_mla, e_mta, e_unl, e_unt, e_spl, e_local;
  assign {e_llo, e_gtl, e_dcl, e_sdc, e_get, e_mla, e_mta, e_unl, e_unt, e_spl, e_local} =
    rise[11:1];

  // =====================================================================
  // talker / listener
  logic talk_r, listen_r;
  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      talk_r <= 1'b0;
      listen_r <= 1'b0;
    end else if (ifc) begin
      talk_r <= 1'b0;
      listen_r <= 1'b0;
    end else begin
      if (e_mta) talk_r <= 1'b1;
      else if (e_unt || e_mla) talk_r <= 1'b0;
      if (e_mla) listen_r <= 1'b1;
      else if (e_unl || e_mta) listen_r <= 1'b0;
    end
  end
  assign TALK_LED = talk_r;
  assign LISTEN_LED = listen_r;

  // =====================================================================
  // remote / lockout
  gbch_rstate_t rstate_r;
  logic lockout_r;
  logic go_local;
  assign go_local = e_gtl || (e_local && !lockout_r);
  always_ff @(posedge REF_CLK) begin
    if (!NRST) rstate_r <= GBCH_LOCAL;
    else begin
      case (rstate_r)
        GBCH_LOCAL: if (!ifc && ren && e_mla) rstate_r <= GBCH_REMOTE;
        GBCH_REMOTE: if (ifc || !ren || go_local) rstate_r <= GBCH_LOCAL;
        default: rstate_r <= GBCH_LOCAL;
      endcase
    end
  end
  always_ff @(posedge REF_CLK) begin
    if (!NRST) lockout_r <= 1'b0;
    else if (!ren) lockout_r <= 1'b0;
    else if (e_llo) lockout_r <= 1'b1;
  end
  assign REMOTE_LED = (rstate_r == GBCH_REMOTE);
  assign LOCKOUT = lockout_r;
  // power is not a gated key, so all eight keys here are ordinary keys
  always_ff @(posedge REF_CLK) begin
    if (!NRST) KEYS_OUT <= '0;
    else if (lockout_r || rstate_r == GBCH_REMOTE) KEYS_OUT <= '0;
    else KEYS_OUT <= keys_s2_r;
  end

  // =====================================================================
  // clears and defaults
  logic restore_r, loop_init_r;
  logic do_clear;
  assign do_clear = e_dcl || (e_sdc && listen_r);
  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      CLEAR_PULSE <= 1'b1;
      SLAVE_CLEAR <= 1'b0;
    end else begin
      CLEAR_PULSE <= do_clear || restore_r;
      SLAVE_CLEAR <= do_clear && SLAVE_MODE == 1'b0 && loop_init_r;
    end
  end
  logic [2:0] tsrc_r;
  logic [4:0] addr_r;
  always_ff @(posedge REF_CLK) begin
    if (!NRST || CLEAR_PULSE) begin
      RELAY_STEP <= GBCH_RELAY_STEP_DEF;
      MEM_STEP <= GBCH_MEM_STEP_DEF;
      RELAYS_OPEN <= 1'b1;
      EDIT_PTR_RELAYS <= 1'b1;
      tsrc_r <= GBCH_TRIG_SRC_EXT;
    end else if (AVS_WRITE && AVS_ADDRESS == GBCH_REG_MODE) begin
      tsrc_r <= AVS_WRITEDATA[GBCH_MODE_TSRC_LSB +: 3];
      RELAYS_OPEN <= 1'b0;
      EDIT_PTR_RELAYS <= 1'b0;
    end
  end
  // address survives every clear and the restore command
  always_ff @(posedge REF_CLK) begin
    if (!NRST) addr_r <= GBCH_ADDR_DEFAULT;
    else if (AVS_WRITE && AVS_ADDRESS == GBCH_REG_MODE && AVS_WRITEDATA[GBCH_MODE_ADDR_WE])
      addr_r <= AVS_WRITEDATA[GBCH_MODE_ADDR_LSB +: 5];
  end
  assign BUS_ADDR = addr_r;
  // master/slave: untouched by clears
  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      SLAVE_MODE <= 1'b0;
      loop_init_r <= 1'b0;
    end else if (AVS_WRITE && AVS_ADDRESS == GBCH_REG_CTRL) begin
      SLAVE_MODE <= AVS_WRITEDATA[GBCH_CTRL_SLAVE_INIT];
      loop_init_r <= AVS_WRITEDATA[GBCH_CTRL_GO_LOOP];
    end
  end
  always_ff @(posedge REF_CLK) begin
    if (!NRST) restore_r <= 1'b0;
    else restore_r <= AVS_WRITE && AVS_ADDRESS == GBCH_REG_CTRL &&
                      AVS_WRITEDATA[GBCH_CTRL_RESTORE];
  end

  // =====================================================================
  // trigger and serial poll
  always_ff @(posedge REF_CLK) begin
    if (!NRST) TRIG_START <= 1'b0;
    else TRIG_START <= e_get && tsrc_r == GBCH_TRIG_SRC_GET;
  end
  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      SPOLL_BYTE <= '0;
      SPOLL_VALID <= 1'b0;
    end else begin
      SPOLL_VALID <= e_spl;
      if (e_spl) SPOLL_BYTE <= SPOLL_STATUS;
    end
  end

  // =====================================================================
  // avalon slave: writes take no wait state; reads take one so that read
  // data leave a flip-flop instead of a mux straight off the address pins
  logic rd_ack_r;
  logic [31:0] rdata_nxt;
  assign AVS_WAITREQUEST = AVS_READ && !rd_ack_r;
  always_ff @(posedge REF_CLK) begin
    if (!NRST) rd_ack_r <= 1'b0;
    else rd_ack_r <= AVS_READ && !rd_ack_r;
  end
  always_comb begin
    case (AVS_ADDRESS)
      GBCH_REG_CTRL: rdata_nxt = {29'h0, loop_init_r, SLAVE_MODE, 1'b0};
      GBCH_REG_STAT: rdata_nxt = {27'h0, lockout_r, REMOTE_LED, listen_r, talk_r, ren};
      GBCH_REG_MODE: rdata_nxt = {19'h0, addr_r, 5'h0, tsrc_r};
      GBCH_REG_SPOLL: rdata_nxt = {24'h0, SPOLL_BYTE};
      default: rdata_nxt = 32'h0;
    endcase
  end
  always_ff @(posedge REF_CLK) begin
    if (!NRST) AVS_READDATA <= 32'h0;
    else if (AVS_READ) AVS_READDATA <= rdata_nxt;
  end

  // =====================================================================
  // assertions
  sequence s_listen_ren;
    ren && e_mla && !ifc;
  endsequence
  property p_remote_entry;
    @(posedge REF_CLK) disable iff (!NRST)
    $rose(REMOTE_LED) |-> $past(ren) && $past(e_mla);
  endproperty
  a_remote_entry: assert property (p_remote_entry) else $error("remote without listen");
  property p_remote_go;
    @(posedge REF_CLK) disable iff (!NRST)
    (!REMOTE_LED ##0 s_listen_ren) |=> REMOTE_LED;
  endproperty
  a_remote_go: assert property (p_remote_go) else $error("remote not entered");
  property p_ifc_idle;
    @(posedge REF_CLK) disable iff (!NRST)
    ifc |=> !TALK_LED && !LISTEN_LED && !REMOTE_LED;
  endproperty
  a_ifc_idle: assert property (p_ifc_idle) else $error("ifc left state");
  property p_keys_blocked;
    @(posedge REF_CLK) disable iff (!NRST)
    (REMOTE_LED || LOCKOUT) |=> KEYS_OUT == 8'h00;
  endproperty
  a_keys_blocked: assert property (p_keys_blocked) else $error("keys leaked");
  property p_talk;
    @(posedge REF_CLK) disable iff (!NRST)
    (e_mta && !ifc) |=> TALK_LED;
  endproperty
  a_talk: assert property (p_talk) else $error("not talker");
  property p_lock_hold;
    @(posedge REF_CLK) disable iff (!NRST)
    (LOCKOUT && ren) |=> LOCKOUT;
  endproperty
  a_lock_hold: assert property (p_lock_hold) else $error("lockout dropped");
  property p_local_key;
    @(posedge REF_CLK) disable iff (!NRST)
    (REMOTE_LED && LOCKOUT && e_local && !e_gtl && ren && !ifc) |=> REMOTE_LED;
  endproperty
  a_local_key: assert property (p_local_key) else $error("local key under lockout");
  property p_sdc;
    @(posedge REF_CLK) disable iff (!NRST)
    (e_sdc && !LISTEN_LED && !e_dcl && !restore_r) |=> !CLEAR_PULSE;
  endproperty
  a_sdc: assert property (p_sdc) else $error("sdc unaddressed");
  property p_clear_defaults;
    @(posedge REF_CLK) disable iff (!NRST)
    CLEAR_PULSE |=> RELAY_STEP == 9'h000 && MEM_STEP == 9'h001 && RELAYS_OPEN;
  endproperty
  a_clear_defaults: assert property (p_clear_defaults) else $error("defaults missing");
  property p_get;
    @(posedge REF_CLK) disable iff (!NRST)
    TRIG_START |-> $past(tsrc_r) == GBCH_TRIG_SRC_GET;
  endproperty
  a_get: assert property (p_get) else $error("trigger from wrong source");
  property p_dcl_addr;
    @(posedge REF_CLK) disable iff (!NRST)
    (e_dcl && !AVS_WRITE) |=> ##1 BUS_ADDR == $past(BUS_ADDR, 2);
  endproperty
  a_dcl_addr: assert property (p_dcl_addr) else $error("address changed by clear");
  property p_dcl_any;
    @(posedge REF_CLK) disable iff (!NRST)
    e_dcl |=> CLEAR_PULSE;
  endproperty
  a_dcl_any: assert property (p_dcl_any) else $error("device clear ignored");
  property p_sdc_listen;
    @(posedge REF_CLK) disable iff (!NRST)
    (e_sdc && LISTEN_LED) |=> CLEAR_PULSE;
  endproperty
  a_sdc_listen: assert property (p_sdc_listen) else $error("addressed sdc ignored");
  property p_gtl;
    @(posedge REF_CLK) disable iff (!NRST)
    (REMOTE_LED && e_gtl) |=> !REMOTE_LED;
  endproperty
  a_gtl: assert property (p_gtl) else $error("go to local ignored");
  property p_ren_unlock;
    @(posedge REF_CLK) disable iff (!NRST)
    !ren |=> !LOCKOUT;
  endproperty
  a_ren_unlock: assert property (p_ren_unlock) else $error("lockout kept without ren");
  // a control write in the clear cycle may legally reconfigure the loop
  sequence s_clear_quiet;
    CLEAR_PULSE && !(AVS_WRITE && AVS_ADDRESS == GBCH_REG_CTRL);
  endsequence
  property p_ms_keep;
    @(posedge REF_CLK) disable iff (!NRST)
    s_clear_quiet |=> $stable(SLAVE_MODE) && $stable(loop_init_r);
  endproperty
  a_ms_keep: assert property (p_ms_keep) else $error("clear changed master/slave");
endmodule
`default_nettype wire

/* rtl/gbch_pkg.sv */
// package: constants and types for the general bus command handler
// =====================================================================
// Functional notes
// - remote only when listen-addressed with ren true
// - interface clear: local, talker and listener idle
// - interface clear turns talk/listen indicators off
// - remote ignores keys except local and power
// - talker when addressed, remote or local
// - lockout disables all keys except power
// - go to local leaves remote; lockout still blocks keys
// - lockout clears only when ren goes false
// - device clear restores defaults, keeps bus address
// - selective clear acts only while listen-addressed
// - group trigger starts change only with bus source
// - serial poll byte returned on every poll
// - defaults: relays open, steps 000/001, edit relays
// - mode defaults restored on power-up and clear
// - address default 18; restore keeps address, setups
// - power up stand-alone; slave only by loop init
// - clears keep master/slave, but clear slaves
// - local key cancels remote unless locked out
package gbch_pkg;
  localparam logic [4:0] GBCH_ADDR_DEFAULT = 5'h12;
  localparam logic [8:0] GBCH_RELAY_STEP_DEF = 9'h000;
  localparam logic [8:0] GBCH_MEM_STEP_DEF = 9'h001;
  localparam logic [2:0] GBCH_DIGOUT_DEF = 3'h0;
  localparam logic [3:0] GBCH_SETTLE_DEF = 4'h0;
  localparam logic [2:0] GBCH_TRIG_SRC_EXT = 3'h7;
  localparam logic [2:0] GBCH_TRIG_SRC_GET = 3'h3;
  localparam logic [1:0] GBCH_TERM_CRLF = 2'h0;
  // avalon register offsets (byte addresses)
  localparam logic [3:0] GBCH_REG_CTRL = 4'h0;
  localparam logic [3:0] GBCH_REG_STAT = 4'h4;
  localparam logic [3:0] GBCH_REG_MODE = 4'h8;
  localparam logic [3:0] GBCH_REG_SPOLL = 4'hC;
  // ctrl bit positions
  localparam int GBCH_CTRL_RESTORE = 0;
  localparam int GBCH_CTRL_SLAVE_INIT = 1;
  localparam int GBCH_CTRL_GO_LOOP = 2;
  // mode field positions
  localparam int GBCH_MODE_TSRC_LSB = 0;
  localparam int GBCH_MODE_ADDR_LSB = 8;
  localparam int GBCH_MODE_ADDR_WE = 16;
  typedef enum logic [1:0] {
    GBCH_LOCAL = 2'b00,
    GBCH_REMOTE = 2'b01
  } gbch_rstate_t;
endpackage

/* testbench/gbch_ctrl_model.sv */
// bus controller model: drives remote enable, interface clear and decoded commands
`timescale 1ns/1ps
`default_nettype none
module gbch_ctrl_model (
  input wire logic clk,
  output logic ren,
  output logic ifc,
  output logic [9:0] cmd
);
  integer seed_m = 32'h68F0888D;
  initial begin
    ren = 1'b0;
    ifc = 1'b0;
    cmd = 10'h000;
  end
  // =====================================================================
  // command strobes
  // index 10 is interface clear; hold time varies so both prompt and slow
  // controllers are seen, never under the three cycles the receiver needs
  task automatic send(input int idx);
    int hold;
    hold = 3 + ($unsigned($random(seed_m)) % 4);
    @(posedge clk);
    if (idx == 10) ifc <= 1'b1;
    else cmd[idx] <= 1'b1;
    repeat (hold) @(posedge clk);
    ifc <= 1'b0;
    cmd <= 10'h000;
    repeat (hold) @(posedge clk);
  endtask
  // lockout is only cancelled by dropping remote enable
  task automatic set_ren(input logic v);
    @(posedge clk);
    ren <= v;
    repeat (6) @(posedge clk);
  endtask
endmodule
`default_nettype wire

/* testbench/gpib_general_command_handler_tb.sv */
// testbench: general bus command handler against a controller model
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin err_total++; \
  $display("unexpected at %0t: got %h want %h", $time, (a), (b)); end end
module gpib_general_command_handler_tb import gbch_pkg::*;;
  logic REF_CLK = 1'b0, NRST = 1'b0, KEY_LOCAL = 1'b0, AVS_READ = 1'b0, AVS_WRITE = 1'b0;
  logic REN, IFC, AVS_WAITREQUEST, TALK_LED, LISTEN_LED, REMOTE_LED, LOCKOUT, CLEAR_PULSE;
  logic SLAVE_CLEAR, TRIG_START, SPOLL_VALID, SLAVE_MODE, RELAYS_OPEN, EDIT_PTR_RELAYS;
  logic [9:0] cmd;
  logic [7:0] SPOLL_STATUS = 8'h00, KEYS_IN = 8'h00, KEYS_OUT, SPOLL_BYTE;
  logic [3:0] AVS_ADDRESS = 4'h0;
  logic [31:0] AVS_WRITEDATA = 32'h0, AVS_READDATA, q;
  logic [8:0] RELAY_STEP, MEM_STEP;
  logic [4:0] BUS_ADDR, a;
  int err_total = 0, n_compared = 0, n_clr = 0, n_slclr = 0, n_trig = 0, n_poll = 0;
  integer seed = 32'h68F0888D;
  gbch_ctrl_model u_gbch_ctrl_model (.clk(REF_CLK), .ren(REN), .ifc(IFC), .cmd(cmd));
  gbch_handler u_gbch_handler (.REF_CLK(REF_CLK), .NRST(NRST), .REN(REN), .IFC(IFC),
    .CMD_LLO(cmd[0]), .CMD_GTL(cmd[1]), .CMD_DCL(cmd[2]), .CMD_SDC(cmd[3]), .CMD_GET(cmd[4]),
    .CMD_MLA(cmd[5]), .CMD_MTA(cmd[6]), .CMD_UNL(cmd[7]), .CMD_UNT(cmd[8]),
    .CMD_SPOLL(cmd[9]), .SPOLL_STATUS(SPOLL_STATUS), .KEY_LOCAL(KEY_LOCAL), .KEYS_IN(KEYS_IN),
    .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
    .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_READDATA(AVS_READDATA),
    .AVS_WAITREQUEST(AVS_WAITREQUEST), .TALK_LED(TALK_LED), .LISTEN_LED(LISTEN_LED),
    .REMOTE_LED(REMOTE_LED), .LOCKOUT(LOCKOUT), .KEYS_OUT(KEYS_OUT),
    .CLEAR_PULSE(CLEAR_PULSE), .SLAVE_CLEAR(SLAVE_CLEAR), .TRIG_START(TRIG_START),
    .SPOLL_BYTE(SPOLL_BYTE), .SPOLL_VALID(SPOLL_VALID), .SLAVE_MODE(SLAVE_MODE),
    .RELAY_STEP(RELAY_STEP), .MEM_STEP(MEM_STEP), .RELAYS_OPEN(RELAYS_OPEN),
    .EDIT_PTR_RELAYS(EDIT_PTR_RELAYS), .BUS_ADDR(BUS_ADDR));
  always #4 REF_CLK = ~REF_CLK;
  // =====================================================================
  // pulse monitors: one-cycle outputs are counted so none slips past a check
  always @(posedge REF_CLK) begin
    if (CLEAR_PULSE === 1'b1) n_clr++;
    if (SLAVE_CLEAR === 1'b1) n_slclr++;
    if (TRIG_START === 1'b1) n_trig++;
    if (SPOLL_VALID === 1'b1) n_poll++;
  end
  // =====================================================================
  // helpers
  function automatic logic [7:0] exp_keys(input logic [7:0] k, input logic open);
    return open ? k : 8'h00;
  endfunction
  task automatic w(input int n);
    repeat (n) @(posedge REF_CLK);
    @(negedge REF_CLK);
  endtask
  task automatic pin(input int idx);
    u_gbch_ctrl_model.send(idx);
    w(1);
  endtask
  task automatic av(input logic wr, input logic [3:0] ad, input logic [31:0] d);
    @(posedge REF_CLK);
    AVS_ADDRESS <= ad;
    AVS_WRITEDATA <= d;
    AVS_WRITE <= wr;
    AVS_READ <= !wr;
    do @(posedge REF_CLK); while (AVS_WAITREQUEST !== 1'b0);
    q = AVS_READDATA;
    AVS_WRITE <= 1'b0;
    AVS_READ <= 1'b0;
    w(1);
  endtask
  task automatic mode(input logic we, input logic [4:0] ad, input logic [2:0] src);
    av(1'b1, GBCH_REG_MODE, {15'h0, we, 3'h0, ad, 5'h0, src});
  endtask
  task automatic keys(input logic open);
    @(posedge REF_CLK);
    KEYS_IN <= 8'($random(seed)) | 8'h01;
    w(3);
    `CHK(KEYS_OUT, exp_keys(KEYS_IN, open))
  endtask
  task automatic lkey();
    @(posedge REF_CLK);
    KEY_LOCAL <= 1'b1;
    repeat (4) @(posedge REF_CLK);
    KEY_LOCAL <= 1'b0;
    w(4);
  endtask
  task results;
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge REF_CLK);
    err_total++;
    results();
  end
  // =====================================================================
  // main sequence
  initial begin
    repeat (2) @(posedge REF_CLK);
    NRST <= 1'b1;
    w(2);
    {n_clr, n_slclr, n_trig, n_poll} = '0;
    `CHK({REMOTE_LED, LOCKOUT, SLAVE_MODE}, 3'b000)
    `CHK({RELAY_STEP, MEM_STEP}, {GBCH_RELAY_STEP_DEF, GBCH_MEM_STEP_DEF})
    `CHK({RELAYS_OPEN, EDIT_PTR_RELAYS, BUS_ADDR}, {2'b11, GBCH_ADDR_DEFAULT})
    u_gbch_ctrl_model.set_ren(1'b1);
    w(1);
    `CHK(REMOTE_LED, 1'b0)
    pin(5);
    `CHK({REMOTE_LED, LISTEN_LED}, 2'b11)
    av(1'b0, GBCH_REG_STAT, 32'h0);
    `CHK(q[4:0], 5'h0D)
    keys(1'b0);
    lkey();
    `CHK(REMOTE_LED, 1'b0)
    keys(1'b1);
    pin(6);
    `CHK({TALK_LED, LISTEN_LED, REMOTE_LED}, 3'b100)
    pin(5);
    pin(10);
    `CHK({TALK_LED, LISTEN_LED}, 2'b00)
    `CHK(REMOTE_LED, 1'b0)
    pin(5);
    pin(0);
    `CHK(LOCKOUT, 1'b1)
    lkey();
    `CHK(REMOTE_LED, 1'b1)
    pin(1);
    `CHK(REMOTE_LED, 1'b0)
    keys(1'b0);
    u_gbch_ctrl_model.set_ren(1'b0);
    w(1);
    `CHK(LOCKOUT, 1'b0)
    keys(1'b1);
    pin(7);
    a = 5'($random(seed));
    mode(1'b1, a, GBCH_TRIG_SRC_EXT);
    av(1'b1, GBCH_REG_CTRL, 32'h4);
    `CHK({BUS_ADDR, RELAYS_OPEN, SLAVE_MODE}, {a, 2'b00})
    pin(2);
    `CHK({n_clr, n_slclr}, {32'd1, 32'd1})
    `CHK({RELAYS_OPEN, EDIT_PTR_RELAYS, BUS_ADDR, SLAVE_MODE}, {2'b11, a, 1'b0})
    av(1'b0, GBCH_REG_CTRL, 32'h0);
    `CHK(q[2:0], 3'b100)
    `CHK({RELAY_STEP, MEM_STEP}, {GBCH_RELAY_STEP_DEF, GBCH_MEM_STEP_DEF})
    mode(1'b0, 5'h00, GBCH_TRIG_SRC_GET);
    pin(3);
    `CHK({n_clr, 1'b0, RELAYS_OPEN}, {32'd1, 2'b00})
    pin(5);
    pin(3);
    `CHK({n_clr, RELAYS_OPEN}, {32'd2, 1'b1})
    av(1'b0, GBCH_REG_MODE, 32'h0);
    `CHK(q[2:0], GBCH_TRIG_SRC_EXT)
    pin(4);
    `CHK(n_trig, 0)
    mode(1'b0, 5'h00, GBCH_TRIG_SRC_GET);
    pin(4);
    `CHK(n_trig, 1)
    for (int i = 1; i <= 3; i++) begin
      @(posedge REF_CLK);
      SPOLL_STATUS <= 8'($random(seed));
      pin(9);
      `CHK({SPOLL_BYTE, n_poll}, {SPOLL_STATUS, i})
    end
    av(1'b1, GBCH_REG_CTRL, 32'h1);
    w(1);
    `CHK({BUS_ADDR, RELAYS_OPEN}, {a, 1'b1})
    av(1'b0, 4'h1, 32'h0);
    `CHK(q, 32'h0)
    results();
  end
endmodule
`default_nettype wire
